// [verilog/ddrk_pkg.sv]
`default_nettype none
package ddrk_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 100;  // System clock period
  localparam int T_DELAY_NS  = 20;   // Clock keep-alive after CKE drop
  localparam int T_MOD_NS    = 12;   // Mode-update delay
  localparam int T_DELAY_CYC = (T_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_MOD_CYC   = (T_MOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 12;   // Width of the sequence counter
  localparam int AGE_W       = 8;    // Width of the ODT age counters
  localparam logic [AGE_W-1:0] AGE_MAX = 8'hff;
  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;  // Orders to the device
  localparam logic [7:0] OFS_EMR  = 8'h04;  // Termination value
  localparam logic [7:0] OFS_STAT = 8'h08;  // Controller status
  localparam int CTRL_RST  = 0;     // Hold device in CKE reset
  localparam int CTRL_PD   = 1;     // Request power-down
  localparam int CTRL_ODT  = 2;     // Wanted ODT level
  localparam int CTRL_SLOW = 3;     // Slow-exit power-down selected
  localparam int CTRL_ROW  = 4;     // A row is open
  localparam int CTRL_W    = 5;
  localparam int ADDR_A2   = 2;     // Termination value, low bit
  localparam int ADDR_A6   = 6;     // Termination value, high bit
  localparam logic [1:0]  BA_EMR     = 2'h1;
  localparam logic [1:0]  RESP_OK    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [CTRL_W-1:0] CTRL_RST_VAL = 5'h01;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } ddrk_cmd_t;
  localparam ddrk_cmd_t CMD_NOP = 4'h7;
  localparam ddrk_cmd_t CMD_LM  = 4'h0;
  typedef struct packed {
    logic        ck_run;  // Differential clock running
    logic        cke;
    logic        odt;
    ddrk_cmd_t   cmd;
    logic [1:0]  ba;
    logic [13:0] addr;
  } ddrk_pins_t;
  localparam ddrk_pins_t PINS_RST = '{1'b0, 1'b0, 1'b0, CMD_NOP, 2'h0, 14'h0000};
  typedef enum logic [3:0] {
    S_RDLY, S_RHOLD, S_STAB, S_INIT, S_OFF, S_LM, S_MOD, S_ACT, S_PD
  } ddrk_state_t;
endpackage
`default_nettype wire

// [verilog/ddrk_ctrl.sv]
// Operation
// - Keep clock running tDELAY after CKE drops
// - Stable clock before CKE, then full init
// - Only NOP or DESELECT during reset
// - ODT free except self refresh, post-enable
// - Late turn-off before entry uses tAOFPD
// - Late turn-on before entry uses tAONPD
// - Early turn-off after exit uses tAOFPD
// - Early turn-on after slow exit uses tAONPD
// - Wait tAOFD before termination load mode
// - Hold ODT low through tMOD window
// - NOP only on power-down entry and exit
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module ddrk_ctrl import ddrk_pkg::*; #(
  parameter int T_INIT_CYC = 2000,  // Power-up initialization wait
  parameter int T_STAB_CYC = 2,     // Stable clock before CKE rises
  parameter int T_AOFD_CYC = 3,     // ODT turn-off delay
  parameter int T_ANPD_CYC = 3,     // ODT to power-down entry
  parameter int T_AXPD_CYC = 8,     // Power-down exit to ODT
  parameter int T_CKE_CYC  = 3      // Minimum CKE level time
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output ddrk_pins_t       DDR
);
  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl, next_ctrl;      // Orders from software
  logic [1:0]        rtt, next_rtt;        // Wanted termination value
  logic              emr_upd, next_emr_upd; // Load mode still owed
  logic              next_awready, next_wready, next_bvalid;
  logic              next_arready, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [31:0]       next_rdata;
  ddrk_state_t       state, next_state;    // Sequencer state
  logic              init_done, next_init; // Initialization finished
  logic              odt_async, next_async; // Delay class in force
  logic [1:0]        rtt_cur, next_rtt_cur; // Value loaded in the device
  logic [CNT_W-1:0]  cnt, next_cnt;        // Sequence wait counter
  logic [AGE_W-1:0]  odt_age, next_odt_age; // Cycles since ODT changed
  logic [AGE_W-1:0]  exit_age, next_exit_age; // Cycles since power-down exit
  logic [AGE_W-1:0]  odt_low, next_odt_low; // Cycles ODT has been low
  ddrk_pins_t        next_d;
  logic              pam;                  // Power-down uses async delays
  logic              wr_go, rd_go;
  assign wr_go = AWREADY && AWVALID && WVALID;
  assign rd_go = ARREADY && ARVALID;

  // Next values of the bus side; address and data are taken together
  always_comb begin
    next_ctrl    = ctrl;
    next_rtt     = rtt;
    next_awready = AWVALID && WVALID && !AWREADY && !BVALID;
    next_wready  = AWVALID && WVALID && !AWREADY && !BVALID;
    next_bvalid  = BVALID && !BREADY;
    next_bresp   = BRESP;
    next_arready = ARVALID && !ARREADY && !RVALID;
    next_rvalid  = RVALID && !RREADY;
    next_rdata   = RDATA;
    next_rresp   = RRESP;
    // Issued load mode clears the owed flag; a new write sets it again
    next_emr_upd = emr_upd && (state != S_LM);
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp  = RESP_OK;
      if (AWADDR == OFS_CTRL) begin
        if (WSTRB[0]) begin
          next_ctrl = WDATA[CTRL_W-1:0];
        end
      end else if (AWADDR == OFS_EMR) begin
        if (WSTRB[0]) begin
          next_rtt     = WDATA[1:0];
          next_emr_upd = 1'b1;               // Set wins over clear
        end
      end else if (AWADDR != OFS_STAT) begin
        next_bresp = RESP_SLVERR;            // Unmapped address
      end
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OK;
      unique case (ARADDR)
        OFS_CTRL: next_rdata = {27'h0, ctrl};
        OFS_EMR:  next_rdata = {30'h0, rtt};
        OFS_STAT: next_rdata = {20'h0, 4'(state), 1'b0, emr_upd, DDR.cke,
                                DDR.ck_run, DDR.odt, odt_async,
                                state == S_PD, init_done};
        default: begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // Bus-side registers; reset holds the device in CKE reset
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl    <= CTRL_RST_VAL;
      rtt     <= 2'h0;
      emr_upd <= 1'b0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= RESP_OK;
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0;
      RRESP   <= RESP_OK;
    end else begin
      ctrl    <= next_ctrl;
      rtt     <= next_rtt;
      emr_upd <= next_emr_upd;
      AWREADY <= next_awready;
      WREADY  <= next_wready;
      BVALID  <= next_bvalid;
      BRESP   <= next_bresp;
      ARREADY <= next_arready;
      RVALID  <= next_rvalid;
      RDATA   <= next_rdata;
      RRESP   <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // Device sequencer
  // ----------------------------------------------------------------
  assign pam = ctrl[CTRL_SLOW] || !ctrl[CTRL_ROW];
  // Next pin values; commands stay NOP except the one load mode cycle
  always_comb begin
    next_state    = state;
    next_cnt      = (cnt != '0) ? cnt - 1'b1 : cnt;
    next_d        = DDR;
    next_d.cmd    = CMD_NOP;
    next_d.ba     = 2'h0;
    next_d.addr   = 14'h0000;
    next_init     = init_done;
    next_rtt_cur  = rtt_cur;
    next_async    = odt_async;
    next_exit_age = (exit_age == AGE_MAX) ? exit_age : exit_age + 1'b1;
    unique case (state)
      S_RDLY: begin
        if (cnt == '0) begin
          next_d.ck_run = 1'b0;
          next_state    = S_RHOLD;
        end
      end
      S_RHOLD: begin
        if (!ctrl[CTRL_RST]) begin
          next_d.ck_run = 1'b1;
          next_cnt      = CNT_W'(T_STAB_CYC);
          next_state    = S_STAB;
        end
      end
      S_STAB: begin
        if (cnt == '0) begin
          next_d.cke = 1'b1;
          next_cnt   = CNT_W'(T_INIT_CYC);
          next_state = S_INIT;
        end
      end
      S_INIT: begin
        // Read data completing after CKE rises is simply not sampled
        if (cnt == '0) begin
          next_state = S_OFF;
        end
      end
      S_OFF: begin
        if (odt_low >= AGE_W'(T_AOFD_CYC)) begin
          next_d.cmd           = CMD_LM;
          next_d.ba            = BA_EMR;
          next_d.addr[ADDR_A2] = rtt[0];
          next_d.addr[ADDR_A6] = rtt[1];
          next_state           = S_LM;
        end
      end
      S_LM: begin
        next_rtt_cur = rtt;
        next_cnt     = CNT_W'(T_MOD_CYC);
        next_state   = S_MOD;
      end
      S_MOD: begin
        if (cnt == '0) begin
          next_init  = 1'b1;
          next_state = S_ACT;
        end
      end
      S_ACT: begin
        if (emr_upd) begin
          next_state = S_OFF;
        end else if (ctrl[CTRL_PD] && cnt == '0) begin
          next_d.cke = 1'b0;
          next_cnt   = CNT_W'(T_CKE_CYC);
          next_state = S_PD;
        end
      end
      S_PD: begin
        if (!ctrl[CTRL_PD] && cnt == '0) begin
          next_d.cke    = 1'b1;
          next_cnt      = CNT_W'(T_CKE_CYC);
          next_exit_age = '0;
          next_state    = S_ACT;
        end
      end
    endcase
    // ODT only once termination is loaded and settled
    next_d.odt = ctrl[CTRL_ODT] && (rtt_cur != 2'h0) &&
                 (next_state == S_ACT || next_state == S_PD);
    // Predict which delay set the device will apply
    if (next_d.odt != DDR.odt) begin
      next_async = (state == S_PD && pam) ||
                   (next_state == S_PD && state == S_ACT) ||
                   (state == S_ACT && exit_age < AGE_W'(T_AXPD_CYC) &&
                    (DDR.odt || pam));
    end else if (state == S_ACT && next_state == S_PD) begin
      next_async = pam || (odt_age < AGE_W'(T_ANPD_CYC));
    end else if (state == S_PD && next_state == S_ACT) begin
      next_async = 1'b0;
    end
    // Reset order overrides everything: drop CKE, keep the clock alive
    if (ctrl[CTRL_RST] && state != S_RDLY && state != S_RHOLD) begin
      next_d.cke   = 1'b0;
      next_d.odt   = 1'b0;
      next_d.cmd   = CMD_NOP;
      next_d.ba    = 2'h0;
      next_d.addr  = 14'h0000;
      next_cnt     = CNT_W'(T_DELAY_CYC);
      next_init    = 1'b0;
      next_rtt_cur = 2'h0;                               // Contents lost
      next_state   = S_RDLY;
    end
    next_odt_age = (next_d.odt != DDR.odt) ? '0 :
                   (odt_age == AGE_MAX) ? odt_age : odt_age + 1'b1;
    next_odt_low = next_d.odt ? '0 :
                   (odt_low == AGE_MAX) ? odt_low : odt_low + 1'b1;
  end

  // Sequencer registers; the device starts held in reset, clock stopped
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state     <= S_RHOLD;
      cnt       <= '0;
      DDR       <= PINS_RST;
      init_done <= 1'b0;
      rtt_cur   <= 2'h0;
      odt_async <= 1'b0;
      odt_age   <= AGE_MAX;
      exit_age  <= AGE_MAX;
      odt_low   <= AGE_MAX;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      DDR       <= next_d;
      init_done <= next_init;
      rtt_cur   <= next_rtt_cur;
      odt_async <= next_async;
      odt_age   <= next_odt_age;
      exit_age  <= next_exit_age;
      odt_low   <= next_odt_low;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [AGE_W-1:0] cke_lo;  // Helper: cycles CKE has been low
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cke_lo <= '0;
    end else begin
      cke_lo <= DDR.cke ? '0 : (cke_lo == AGE_MAX) ? cke_lo : cke_lo + 1'b1;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  chk_clock_stop_delay: assert property (
    $fell(DDR.ck_run) |-> !DDR.cke && cke_lo > AGE_W'(T_DELAY_CYC))
    else $error("clock stopped too soon after CKE drop");
  chk_clock_before_cke: assert property (
    $rose(DDR.cke) && !$past(init_done) |-> DDR.ck_run && $past(DDR.ck_run, 2))
    else $error("CKE raised without a stable clock");
  chk_nop_cke_edges: assert property (
    (!DDR.cke || $changed(DDR.cke)) |-> DDR.cmd == CMD_NOP)
    else $error("command other than NOP around CKE change");
  chk_odt_enabled: assert property (
    DDR.odt |-> rtt_cur != 2'h0 && init_done && (state == S_ACT || state == S_PD))
    else $error("ODT driven before termination settled");
  chk_lm_after_aofd: assert property (
    DDR.cmd == CMD_LM |-> !DDR.odt && $past(!DDR.odt, 3))
    else $error("load mode issued before ODT off delay");
  chk_odt_low_mod: assert property (
    DDR.cmd == CMD_LM |=> !DDR.odt [*2])
    else $error("ODT raised inside mode-update window");
  chk_late_entry: assert property (
    state == S_ACT && next_state == S_PD && next_d.odt == DDR.odt &&
    odt_age < AGE_W'(T_ANPD_CYC) |=> odt_async)
    else $error("late ODT change before entry not marked async");
  chk_early_exit_off: assert property (
    state == S_ACT && next_state == S_ACT && DDR.odt && !next_d.odt &&
    exit_age < AGE_W'(T_AXPD_CYC) |=> odt_async)
    else $error("early ODT turn-off after exit not marked async");
  chk_early_exit_on: assert property (
    state == S_ACT && next_state == S_ACT && !DDR.odt && next_d.odt && pam &&
    exit_age < AGE_W'(T_AXPD_CYC) |=> odt_async)
    else $error("early ODT turn-on after slow exit not marked async");
  chk_pd_async_mode: assert property (
    state == S_PD && next_state == S_PD && pam && next_d.odt != DDR.odt |=> odt_async)
    else $error("ODT change in slow power-down not marked async");
endmodule
`default_nettype wire

// [verif/ddrk_dev_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Behavioural memory device facing the controller pins
// ----------------------------------------------------------------
module ddrk_dev_model import ddrk_pkg::*; (
  input  wire logic       CLK,
  input  wire logic       NRST,
  input  wire ddrk_pins_t DDR,        // Pins driven by the controller
  input  wire logic       slow_pd,    // Bench says slow-exit or precharge mode
  output logic [1:0]      rtt,        // Loaded termination value
  output logic            bad_cmd,    // Sticky: controller broke a pin rule
  output logic            data_ok,    // Contents valid since last load
  output logic            async_cls   // Power-down delay class in force
);
  // ----------------------------------------------------------------
  // Pin sampling on every rising CLK edge, whether the clock is running or not
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rtt     <= 2'h0;
      bad_cmd <= 1'b0;
      data_ok <= 1'b0;
    end else begin
      // CKE may only rise on a running clock
      if (DDR.cke && !DDR.ck_run) begin
        bad_cmd <= 1'b1;
      end
      // Anything but NOP while CKE is low is a fault
      if (!DDR.cke && (DDR.cmd !== CMD_NOP)) begin
        bad_cmd <= 1'b1;
      end
      if (!DDR.cke && !DDR.ck_run) begin
        // Reset state: contents lost, other pins ignored; a cut read
        // may finish when CKE rises, but no data pins exist here
        data_ok <= 1'b0;
      end else if (DDR.cke && (DDR.cmd === CMD_LM) && (DDR.ba === BA_EMR)) begin
        // New termination value taken at once, well inside tMOD
        rtt     <= {DDR.addr[ADDR_A6], DDR.addr[ADDR_A2]};
        data_ok <= 1'b1;
        // Termination must be off while the value changes
        if (DDR.odt) begin
          bad_cmd <= 1'b1;
        end
      end
    end
  end
  // Delay class follows CKE and the power-down kind
  assign async_cls = !DDR.cke && DDR.ck_run && slow_pd;
endmodule
`default_nettype wire

// [verif/ddrk_ctrl_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module ddrk_ctrl_tb_top import ddrk_pkg::*;;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        CLK, NRST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP, rtt, rs;
  logic        bad_cmd, data_ok, async_cls, slow_pd, pcke, pck;
  ddrk_pins_t  DDR;
  int          err_count, tests_run, cyc, t_cke, t_ck;
  // Short init wait keeps the run brief
  ddrk_ctrl #(.T_INIT_CYC(5)) dut (.CLK(CLK), .NRST(NRST), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
    .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .DDR(DDR));
  ddrk_dev_model mem (.CLK(CLK), .NRST(NRST), .DDR(DDR), .slow_pd(slow_pd), .rtt(rtt),
    .bad_cmd(bad_cmd), .data_ok(data_ok), .async_cls(async_cls));
  // ----------------------------------------------------------------
  // Clock and edge-time recorder
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // Cycle stamps of CKE and clock-enable falls
  always @(posedge CLK) begin
    cyc  <= cyc + 1;
    pcke <= DDR.cke;
    pck  <= DDR.ck_run;
    if (pcke && !DDR.cke) t_cke <= cyc;
    if (pck && !DDR.ck_run) t_ck <= cyc;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // A wait that ran out counts as a mismatch and closes the run
  task automatic give_up(input string what);
    err_count++;
    $display("wrong value %s expected done seen timeout", what);
    end_sim();
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_on, w_on;
    @(posedge CLK);
    AWADDR <= a; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
    aw_on = 1'b1; w_on = 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(posedge CLK);
      if (!aw_on && !w_on && BVALID === 1'b1) begin
        r = BRESP;
        BREADY <= 1'b0;
        return;
      end
      if (aw_on && AWREADY === 1'b1) begin
        aw_on = 1'b0;
        AWVALID <= 1'b0;
      end
      if (w_on && WREADY === 1'b1) begin
        w_on = 1'b0;
        WVALID <= 1'b0;
      end
    end
    give_up("write response");
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_on;
    @(posedge CLK);
    ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
    ar_on = 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(posedge CLK);
      if (!ar_on && RVALID === 1'b1) begin
        d = RDATA; r = RRESP;
        RREADY <= 1'b0;
        return;
      end
      if (ar_on && ARREADY === 1'b1) begin
        ar_on = 1'b0;
        ARVALID <= 1'b0;
      end
    end
    give_up("read response");
  endtask
  // Poll status until the masked bits match, bounded
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    for (int n = 0; n < 80; n++) begin
      axi_rd(OFS_STAT, rd, rs);
      if ((rd & m) === v) return;
    end
    give_up("status wait");
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_vals;
    cmp("pins at reset", 32'(PINS_RST), 32'(DDR));
    axi_rd(OFS_CTRL, rd, rs);
    cmp("ctrl reset", 32'(CTRL_RST_VAL), rd);
    axi_rd(OFS_STAT, rd, rs);
    cmp("cke ck held", 32'h0, {30'h0, rd[5:4]});
  endtask
  task automatic t_init;
    axi_wr(OFS_CTRL, 32'h0, rs);
    wait_stat(32'h1, 32'h1);
    cmp("state act", 32'h7, {28'h0, rd[11:8]});
    cmp("cke ck up", 32'h3, {30'h0, rd[5:4]});
    cmp("dev loaded", 32'h1, {31'h0, data_ok});
    cmp("pin rules", 32'h0, {31'h0, bad_cmd});
  endtask
  task automatic t_emr;
    axi_wr(OFS_EMR, 32'h2, rs);
    wait_stat(32'h40, 32'h0);
    cmp("rtt loaded", 32'h2, {30'h0, rtt});
    cmp("odt in load", 32'h0, {31'h0, bad_cmd});
  endtask
  task automatic t_odt_pd;
    axi_wr(OFS_CTRL, 32'h4, rs);
    wait_stat(32'h8, 32'h8);
    cmp("sync class", 32'h0, {31'h0, rd[2]});
    slow_pd <= 1'b1;
    axi_wr(OFS_CTRL, 32'h1e, rs);
    wait_stat(32'h2, 32'h2);
    cmp("pd state", 32'h8, {28'h0, rd[11:8]});
    cmp("pd class", 32'h1, {31'h0, rd[2]});
    cmp("pd cke", 32'h0, {31'h0, DDR.cke});
    cmp("dev class", 32'h1, {31'h0, async_cls});
    // Exit with ODT still on, then drop it well inside the exit window
    axi_wr(OFS_CTRL, 32'h1c, rs);
    axi_wr(OFS_CTRL, 32'h18, rs);
    wait_stat(32'ha, 32'h0);
    cmp("early off", 32'h1, {31'h0, rd[2]});
    // Enter again with ODT off, exit, then raise ODT early
    axi_wr(OFS_CTRL, 32'h1a, rs);
    wait_stat(32'h2, 32'h2);
    axi_wr(OFS_CTRL, 32'h18, rs);
    axi_wr(OFS_CTRL, 32'h1c, rs);
    wait_stat(32'ha, 32'h8);
    slow_pd <= 1'b0;
    cmp("early on", 32'h1, {31'h0, rd[2]});
    cmp("pd nop", 32'h0, {31'h0, bad_cmd});
  endtask
  task automatic t_unmapped;
    axi_wr(8'h0c, 32'h1, rs);
    cmp("wr unmapped", 32'(RESP_SLVERR), 32'(rs));
    axi_rd(8'h0c, rd, rs);
    cmp("rd unmapped", 32'(RESP_SLVERR), 32'(rs));
    cmp("rd unmapped data", 32'h0, rd);
    axi_wr(OFS_STAT, 32'hff, rs);
    cmp("wr status", 32'(RESP_OK), 32'(rs));
  endtask
  task automatic t_cke_reset;
    axi_wr(OFS_CTRL, 32'h1, rs);
    wait_stat(32'h30, 32'h0);
    cmp("clock hold", 32'(T_DELAY_CYC + 1), 32'(t_ck - t_cke));
    cmp("data lost", 32'h0, {31'h0, data_ok});
    axi_wr(OFS_CTRL, 32'h0, rs);
    wait_stat(32'h1, 32'h1);
    cmp("reinit", 32'h1, {31'h0, data_ok});
    cmp("reset nop", 32'h0, {31'h0, bad_cmd});
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    NRST = 1'b0; AWVALID = 1'b0; WVALID = 1'b0; BREADY = 1'b0; ARVALID = 1'b0;
    RREADY = 1'b0; AWADDR = 8'h00; ARADDR = 8'h00; WDATA = 32'h0; WSTRB = 4'h1;
    slow_pd = 1'b0; err_count = 0; tests_run = 0; cyc = 0; t_cke = 0; t_ck = 0;
    repeat (10) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    t_reset_vals();
    t_init();
    t_emr();
    t_odt_pd();
    t_unmapped();
    t_cke_reset();
    end_sim();
  end
endmodule
`default_nettype wire
